// ==== hdl/psp_pkg.sv ====
// Constants, encodings and states of the secondary bus port
package psp_pkg;
    // Index of each sustained tri-state control line in the ctl vectors
    localparam int unsigned CTL_FRAME  = 0;
    localparam int unsigned CTL_IRDY   = 1;
    localparam int unsigned CTL_TRDY   = 2;
    localparam int unsigned CTL_DEVSEL = 3;
    localparam int unsigned CTL_STOP   = 4;
    localparam int unsigned CTL_N      = 5;

    // Bus commands used by this port
    localparam logic [3:0] CMD_DAC    = 4'hD;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;

    // Clocks after the address edge by which a target must claim
    localparam logic [2:0] MABORT_CYCLES = 3'h5;

    // Write data queue: {last, byte enables, data}
    localparam int unsigned WQ_DEPTH = 4;
    localparam int unsigned WQ_W     = 37;
    localparam int unsigned WQ_LAST  = 36;
    localparam int unsigned WQ_BE_LO = 32;

    // Levels driven while parking
    localparam logic [31:0] AD_PARK  = 32'h0000_0000;
    localparam logic [3:0]  CBE_PARK = 4'h0;

    // Transaction result codes
    localparam logic [2:0] RES_OK       = 3'h0;
    localparam logic [2:0] RES_MABORT   = 3'h1;
    localparam logic [2:0] RES_TABORT   = 3'h2;
    localparam logic [2:0] RES_RETRY    = 3'h3;
    localparam logic [2:0] RES_DISC     = 3'h4;
    localparam logic [2:0] RES_DISC_DAT = 3'h5;

    typedef enum logic [2:0] {
        PSP_M_IDLE,
        PSP_M_ADDR2,
        PSP_M_DATA,
        PSP_M_LAST
    } psp_mst_e;

    typedef enum logic [1:0] {
        PSP_T_IDLE,
        PSP_T_CLAIM,
        PSP_T_DATA
    } psp_tgt_e;
endpackage

// ==== hdl/psp_stream_if.sv ====
// Valid/ready word carrier between the queue and the port logic
`timescale 1ns/1ps
`default_nettype none
interface psp_stream_if #(
    parameter int unsigned W = 8
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== hdl/psp_fifo.sv ====
// Small synchronous FIFO with registered fill-side ready
`timescale 1ns/1ps
`default_nettype none
module psp_fifo #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output var  logic         in_ready,
    psp_stream_if.src         o
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
        logic                    in_ready;
    } psp_fifo_s;

    psp_fifo_s q;
    psp_fifo_s d;
    logic      push;
    logic      pop;

    assign o.valid  = (q.cnt != '0);
    assign o.data   = q.mem[q.rp];
    assign in_ready = q.in_ready;

    always_comb begin
        d    = q;
        push = in_valid & q.in_ready;
        pop  = o.valid & o.ready;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp        = (q.wp == AW'(DEPTH - 1)) ? '0 : AW'(q.wp + 1'b1);
        end
        if (pop) begin
            d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : AW'(q.rp + 1'b1);
        end
        if (push && !pop) begin
            d.cnt = (AW + 1)'(q.cnt + 1'b1);
        end else if (pop && !push) begin
            d.cnt = (AW + 1)'(q.cnt - 1'b1);
        end
        // Registered ready; pessimistic by one cycle when draining from full
        d.in_ready = (d.cnt < (AW + 1)'(DEPTH));
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q          <= '0;
            q.in_ready <= 1'b1;
        end else begin
            q <= d;
        end
    end
endmodule // psp_fifo
`default_nettype wire

// ==== hdl/psp_port.sv ====
// Secondary bus port: initiator, positive-decode target, parking, parity
//
// Behaviour
// - Address then data share the 32 AD lines
// - Park AD and CBE when idle under grant
// - Command in address phase; DAC uses two
// - Initiator drives byte enables every data phase
// - Parity is even over AD and CBE
// - Parity follows its address or data by one
// - Parity released one clock after AD released
// - Receivers check parity against received bits
// - Parked parity valid one clock after AD
// - FRAME held until final data phase begins
// - Control lines driven high one clock, released
// - IRDY only with write data or read room
// - Asserted IRDY or TRDY held till phase completes
// - TRDY only when write accepted or data valid
// - Claim only decoded addresses with DEVSEL
// - Master abort without DEVSEL in five clocks
// - STOP with TRDY and DEVSEL: disconnect with data
// - STOP, DEVSEL, no TRDY: disconnect, first phase retry
// - STOP without DEVSEL means target abort
// - Own grant comes from internal arbiter input
`timescale 1ns/1ps
`default_nettype none
module psp_port
    import psp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              own_gnt,
    input  wire logic [31:0]       ad_i,
    output var  logic [31:0]       ad_o,
    output var  logic              ad_oe,
    input  wire logic [3:0]        cbe_i,
    output var  logic [3:0]        cbe_o,
    output var  logic              cbe_oe,
    input  wire logic              par_i,
    output var  logic              par_o,
    output var  logic              par_oe,
    input  wire logic [CTL_N-1:0]  ctl_i,
    output var  logic [CTL_N-1:0]  ctl_o,
    output var  logic [CTL_N-1:0]  ctl_oe,
    input  wire logic              req_valid,
    input  wire logic [3:0]        req_cmd,
    input  wire logic              req_dac,
    input  wire logic [63:0]       req_addr,
    input  wire logic [3:0]        req_rd_be,
    output var  logic              req_ready,
    input  wire logic              wq_valid,
    input  wire logic [WQ_W-1:0]   wq_data,
    output var  logic              wq_ready,
    output var  logic              rd_valid,
    output var  logic [31:0]       rd_data,
    output var  logic              res_valid,
    output var  logic [2:0]        res_code,
    input  wire logic [31:0]       win_base,
    input  wire logic [31:0]       win_limit,
    input  wire logic              tgt_busy,
    input  wire logic              tgt_abort,
    input  wire logic [31:0]       tgt_rd_data,
    output var  logic              tw_valid,
    output var  logic [31:0]       tw_data,
    output var  logic [3:0]        tw_be,
    output var  logic              par_err
);
    typedef struct packed {
        psp_mst_e         ms;
        psp_tgt_e         ts;
        logic [2:0]       cnt;
        logic             dev_seen;
        logic             first;
        logic             flush;
        logic             m_wr;
        logic [3:0]       m_cmd;
        logic [31:0]      m_hi;
        logic [3:0]       m_rbe;
        logic             t_wr;
        logic             t_done;
        logic [31:0]      ad_o;
        logic             ad_oe;
        logic [3:0]       cbe_o;
        logic             cbe_oe;
        logic             par_o;
        logic             par_oe;
        logic [CTL_N-1:0] act;
        logic [CTL_N-1:0] ctl_o;
        logic [CTL_N-1:0] ctl_oe;
        logic             frame_p;
        logic             chk;
        logic             chk_par;
        logic             par_err;
        logic             req_ready;
        logic             rd_valid;
        logic [31:0]      rd_data;
        logic             res_valid;
        logic [2:0]       res_code;
        logic             tw_valid;
        logic [31:0]      tw_data;
        logic [3:0]       tw_be;
    } psp_port_s;

    psp_port_s q;
    psp_port_s d;

    psp_stream_if #(.W(WQ_W)) wq ();

    psp_fifo #(
        .W     (WQ_W),
        .DEPTH (WQ_DEPTH)
    ) u_wq (
        .clk      (clk),
        .rstn     (rstn),
        .in_valid (wq_valid),
        .in_data  (wq_data),
        .in_ready (wq_ready),
        .o        (wq)
    );

    logic       frame_a;
    logic       irdy_a;
    logic       trdy_a;
    logic       devsel_a;
    logic       stop_a;
    logic       bus_idle;
    logic       start;
    logic       m_end;
    logic       hit;
    logic [3:0] pcbe;

    always_comb begin
        d           = q;
        frame_a     = ~ctl_i[CTL_FRAME];
        irdy_a      = ~ctl_i[CTL_IRDY];
        trdy_a      = ~ctl_i[CTL_TRDY];
        devsel_a    = ~ctl_i[CTL_DEVSEL];
        stop_a      = ~ctl_i[CTL_STOP];
        bus_idle    = ~frame_a & ~irdy_a;
        start       = 1'b0;
        m_end       = 1'b0;
        hit         = 1'b0;
        wq.ready    = 1'b0;
        d.act       = '0;
        d.ad_oe     = 1'b0;
        d.cbe_oe    = 1'b0;
        d.chk       = 1'b0;
        d.req_ready = 1'b0;
        d.rd_valid  = 1'b0;
        d.res_valid = 1'b0;
        d.tw_valid  = 1'b0;
        d.frame_p   = ctl_i[CTL_FRAME];

        // Initiator
        unique case (q.ms)
            PSP_M_IDLE: begin
                // Leftover burst words after an early end must not leak
                if (q.flush && wq.valid) begin
                    wq.ready = 1'b1;
                    d.flush  = ~wq.data[WQ_LAST];
                end
                start = own_gnt & req_valid & bus_idle & ~q.flush & (q.ts == PSP_T_IDLE);
                if (start) begin
                    d.act[CTL_FRAME] = 1'b1;
                    d.ad_o        = req_addr[31:0];
                    d.cbe_o       = req_dac ? CMD_DAC : req_cmd;
                    d.ad_oe       = 1'b1;
                    d.cbe_oe      = 1'b1;
                    d.m_cmd       = req_cmd;
                    d.m_wr        = req_cmd[0];
                    d.m_hi        = req_addr[63:32];
                    d.m_rbe       = req_rd_be;
                    d.req_ready   = 1'b1;
                    d.cnt         = '0;
                    d.dev_seen    = 1'b0;
                    d.first       = 1'b1;
                    d.ms          = req_dac ? PSP_M_ADDR2 : PSP_M_DATA;
                end
            end
            PSP_M_ADDR2: begin
                d.act[CTL_FRAME] = 1'b1;
                d.ad_o   = q.m_hi;
                d.cbe_o  = q.m_cmd;
                d.ad_oe  = 1'b1;
                d.cbe_oe = 1'b1;
                d.cnt    = 3'h0;
                d.ms     = PSP_M_DATA;
            end
            PSP_M_DATA: begin
                d.cnt      = (q.cnt == 3'h7) ? q.cnt : 3'(q.cnt + 3'h1);
                d.dev_seen = q.dev_seen | devsel_a;
                d.cbe_oe   = 1'b1;
                d.ad_oe    = q.m_wr;
                if (q.m_wr) begin
                    // Head word stays put until popped, so IRDY cannot drop
                    d.act[CTL_IRDY]  = q.act[CTL_IRDY] | wq.valid;
                    d.act[CTL_FRAME] = q.act[CTL_FRAME] &
                                       ~(d.act[CTL_IRDY] & wq.data[WQ_LAST]);
                    d.ad_o  = wq.data[31:0];
                    d.cbe_o = wq.data[WQ_BE_LO +: 4];
                end else begin
                    // Single-word reads only; bursts are split upstream
                    d.act[CTL_IRDY]  = 1'b1;
                    d.act[CTL_FRAME] = 1'b0;
                    d.cbe_o = q.m_rbe;
                end
                if (q.act[CTL_IRDY] && trdy_a && devsel_a) begin
                    d.first = 1'b0;
                    if (q.m_wr) begin
                        wq.ready = 1'b1;
                        d.flush  = ~wq.data[WQ_LAST];
                        if (!wq.data[WQ_LAST]) begin
                            d.act[CTL_IRDY]  = wq.valid;
                            d.act[CTL_FRAME] = 1'b1;
                        end
                    end else begin
                        d.rd_valid = 1'b1;
                        d.rd_data  = ad_i;
                        d.chk      = 1'b1;
                    end
                    if (stop_a) begin
                        m_end      = 1'b1;
                        d.res_code = RES_DISC_DAT;
                    end else if (!q.act[CTL_FRAME]) begin
                        m_end      = 1'b1;
                        d.res_code = RES_OK;
                    end
                end else if (stop_a && devsel_a) begin
                    m_end      = 1'b1;
                    d.res_code = q.first ? RES_RETRY : RES_DISC;
                    d.flush    = q.m_wr;
                end else if (stop_a) begin
                    m_end      = 1'b1;
                    d.res_code = RES_TABORT;
                    d.flush    = q.m_wr;
                end else if (!q.dev_seen && !devsel_a && q.cnt == MABORT_CYCLES) begin
                    m_end      = 1'b1;
                    d.res_code = RES_MABORT;
                    d.flush    = q.m_wr;
                end
                if (m_end) begin
                    d.res_valid = 1'b1;
                    d.act       = '0;
                    if (q.act[CTL_FRAME]) begin
                        // FRAME may only drop while IRDY is asserted
                        d.act[CTL_IRDY] = 1'b1;
                        d.ms = PSP_M_LAST;
                    end else begin
                        d.ms = PSP_M_IDLE;
                    end
                end
            end
            PSP_M_LAST: begin
                d.ad_oe  = q.m_wr;
                d.cbe_oe = 1'b1;
                d.ms     = PSP_M_IDLE;
            end
        endcase

        // Target
        unique case (q.ts)
            PSP_T_IDLE: begin
                hit = frame_a & q.frame_p & (q.ms == PSP_M_IDLE) &
                      (ad_i >= win_base) & (ad_i <= win_limit) &
                      ((cbe_i == CMD_MEM_RD) || (cbe_i == CMD_MEM_WR));
                if (hit) begin
                    d.t_wr   = cbe_i[0];
                    d.t_done = 1'b0;
                    d.chk    = 1'b1;
                    d.ts     = PSP_T_CLAIM;
                end
            end
            PSP_T_CLAIM: begin
                d.act[CTL_DEVSEL] = ~tgt_abort;
                d.act[CTL_STOP]   = tgt_abort;
                d.ts = PSP_T_DATA;
            end
            PSP_T_DATA: begin
                d.act[CTL_DEVSEL] = q.act[CTL_DEVSEL] & ~tgt_abort;
                // One word per claim, then disconnect
                d.act[CTL_STOP]   = 1'b1;
                d.act[CTL_TRDY]   = ~q.t_done & d.act[CTL_DEVSEL] &
                                    (q.act[CTL_TRDY] | ~tgt_busy);
                if (!q.t_wr) begin
                    d.ad_oe = 1'b1;
                    d.ad_o  = tgt_rd_data;
                end
                if (irdy_a && q.act[CTL_TRDY]) begin
                    d.t_done        = 1'b1;
                    d.act[CTL_TRDY] = 1'b0;
                    if (q.t_wr) begin
                        d.tw_valid = 1'b1;
                        d.tw_data  = ad_i;
                        d.tw_be    = cbe_i;
                        d.chk      = 1'b1;
                    end
                end
                if (!frame_a && (irdy_a ? (q.act[CTL_TRDY] | q.act[CTL_STOP]) : 1'b1)) begin
                    d.act[CTL_DEVSEL] = 1'b0;
                    d.act[CTL_TRDY]   = 1'b0;
                    d.act[CTL_STOP]   = 1'b0;
                    d.ad_oe           = 1'b0;
                    d.ts              = PSP_T_IDLE;
                end
            end
        endcase

        // Parking under own grant, dropped as soon as grant goes
        if (q.ms == PSP_M_IDLE && !start && q.ts == PSP_T_IDLE && !hit &&
            own_gnt && bus_idle) begin
            d.ad_o   = AD_PARK;
            d.cbe_o  = CBE_PARK;
            d.ad_oe  = 1'b1;
            d.cbe_oe = 1'b1;
        end

        // Control lines: low while asserted, one high clock, then released
        d.ctl_o  = ~d.act;
        d.ctl_oe = d.act | q.act;

        // Parity tracks the word driven one clock earlier, enable likewise
        pcbe     = q.cbe_oe ? q.cbe_o : cbe_i;
        d.par_o  = ^{q.ad_o, pcbe};
        d.par_oe = q.ad_oe;

        // Received word parity, compared when its parity bit arrives
        d.chk_par = ^{ad_i, cbe_i};
        d.par_err = q.chk & (par_i != q.chk_par);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q         <= '0;
            q.ms      <= PSP_M_IDLE;
            q.ts      <= PSP_T_IDLE;
            q.ctl_o   <= '1;
            q.frame_p <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign ad_o      = q.ad_o;
    assign ad_oe     = q.ad_oe;
    assign cbe_o     = q.cbe_o;
    assign cbe_oe    = q.cbe_oe;
    assign par_o     = q.par_o;
    assign par_oe    = q.par_oe;
    assign ctl_o     = q.ctl_o;
    assign ctl_oe    = q.ctl_oe;
    assign req_ready = q.req_ready;
    assign rd_valid  = q.rd_valid;
    assign rd_data   = q.rd_data;
    assign res_valid = q.res_valid;
    assign res_code  = q.res_code;
    assign tw_valid  = q.tw_valid;
    assign tw_data   = q.tw_data;
    assign tw_be     = q.tw_be;
    assign par_err   = q.par_err;
endmodule // psp_port
`default_nettype wire

// ==== tb/psp_port_chk.sv ====
// Concurrent checks on the secondary bus port pins
`timescale 1ns/1ps
`default_nettype none
module psp_port_chk
    import psp_pkg::*;
(
    input wire logic             clk,
    input wire logic             rstn,
    input wire logic [31:0]      ad_i,
    input wire logic             ad_oe,
    input wire logic [3:0]       cbe_i,
    input wire logic             par_o,
    input wire logic             par_oe,
    input wire logic [CTL_N-1:0] ctl_i,
    input wire logic [CTL_N-1:0] ctl_o,
    input wire logic [CTL_N-1:0] ctl_oe,
    input wire logic             res_valid,
    input wire logic [2:0]       res_code
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Own IRDY is sampled asserted at this edge
    sequence s_end;
        ctl_oe[CTL_IRDY] && !ctl_i[CTL_IRDY];
    endsequence
    sequence s_mst_go;
        ctl_oe[CTL_FRAME] && $fell(ctl_i[CTL_FRAME]);
    endsequence
    // Stop counts too, so a target abort never reads as unclaimed
    sequence s_unclaimed;
        (ctl_i[CTL_DEVSEL] && ctl_i[CTL_STOP])[*5];
    endsequence

    a_par_follow: assert property (par_oe == $past(ad_oe))
        else $error("parity enable not one clock behind AD enable");
    a_par_even: assert property (par_oe |-> par_o == ^{$past(ad_i), $past(cbe_i)})
        else $error("driven parity not even over previous AD and CBE");
    a_mst_abort: assert property (s_mst_go ##1 s_unclaimed |-> ##[1:4]
        (res_valid && res_code == RES_MABORT))
        else $error("missing master abort after unclaimed address");
    a_tgt_retry: assert property (s_end ##0 (!ctl_i[CTL_STOP] && !ctl_i[CTL_DEVSEL]
        && ctl_i[CTL_TRDY]) |-> ##[1:3] (res_valid && res_code == RES_RETRY))
        else $error("retry not reported");
    a_tgt_abort: assert property (s_end ##0 (!ctl_i[CTL_STOP] && ctl_i[CTL_DEVSEL])
        |-> ##[1:3] (res_valid && res_code == RES_TABORT))
        else $error("target abort not reported");
    a_disc_data: assert property (s_end ##0 (!ctl_i[CTL_STOP] && !ctl_i[CTL_DEVSEL]
        && !ctl_i[CTL_TRDY]) |-> ##[1:3] (res_valid && res_code == RES_DISC_DAT))
        else $error("disconnect with data not reported");
    a_ctl_release: assert property ((~ctl_oe & $past(ctl_oe) & ~$past(ctl_o)) == '0)
        else $error("control line released without a high clock");
    a_irdy_hold: assert property (ctl_oe[CTL_IRDY] && !ctl_o[CTL_IRDY]
        && !ctl_i[CTL_DEVSEL] && ctl_i[CTL_TRDY] && ctl_i[CTL_STOP] |=> !ctl_o[CTL_IRDY] || res_valid)
        else $error("IRDY dropped before its data phase completed");
endmodule // psp_port_chk

bind psp_port psp_port_chk u_chk (
    .clk(clk), .rstn(rstn), .ad_i(ad_i), .ad_oe(ad_oe), .cbe_i(cbe_i),
    .par_o(par_o), .par_oe(par_oe), .ctl_i(ctl_i), .ctl_o(ctl_o),
    .ctl_oe(ctl_oe), .res_valid(res_valid), .res_code(res_code)
);
`default_nettype wire

// ==== tb/psp_tgt_model.sv ====
// Single word target on the far side of the secondary bus
`timescale 1ns/1ps
`default_nettype none
module psp_tgt_model
    import psp_pkg::*;
(
    input  wire logic             clk,
    input  wire logic [CTL_N-1:0] ctl_w,
    input  wire logic [31:0]      ad_w,
    input  wire logic [3:0]       cbe_w,
    input  wire logic [CTL_N-1:0] mask,
    input  wire logic [31:0]      rdata,
    output var  logic [CTL_N-1:0] m_ctl,
    output var  logic [CTL_N-1:0] m_coe,
    output var  logic [31:0]      m_ad,
    output var  logic             m_aoe,
    output var  logic             m_par,
    output var  logic             m_poe
);
    logic wr;
    int   n;
    always @(posedge clk) begin
        m_par <= ^{ad_w, cbe_w};
        m_poe <= m_aoe;
    end
    // Lines listed in mask are asserted; empty mask leaves it unclaimed
    initial begin
        m_ctl = '1;
        m_coe = '0;
        m_ad  = '0;
        m_aoe = 1'b0;
        forever begin
            @(posedge clk iff ctl_w[CTL_FRAME] === 1'b1);
            @(posedge clk iff ctl_w[CTL_FRAME] === 1'b0);
            if (cbe_w === CMD_DAC) @(posedge clk);
            wr = cbe_w[0];
            if (mask != '0) begin
                m_ctl <= ~(mask & 5'h08);
                m_coe <= 5'h1C;
                @(posedge clk);
                m_ctl <= ~mask;
                m_ad  <= rdata;
                m_aoe <= mask[CTL_TRDY] & ~wr;
                n = 0;
                do begin
                    @(posedge clk);
                    n++;
                end while (ctl_w[CTL_IRDY] !== 1'b0 && n < 16);
                m_ctl <= '1;
                m_aoe <= 1'b0;
                @(posedge clk);
                m_coe <= '0;
            end
        end
    end
endmodule // psp_tgt_model
`default_nettype wire

// ==== tb/pci_bridge_secondary_port_bench.sv ====
// Self-checking bench for the secondary bus port
`timescale 1ns/1ps
`default_nettype none
module pci_bridge_secondary_port_bench import psp_pkg::*;;
    localparam logic [31:0] WD = 32'hA5C3_0F96;
    localparam logic [31:0] RD = 32'h5A3C_F069;
    localparam logic [31:0] WB = 32'h4000_0000;
    logic clk = 1'b0, rstn = 1'b0, own_gnt = 1'b0, req_valid = 1'b0, req_dac = 1'b0;
    logic wq_valid = 1'b0, b_aoe = 1'b0, b_par = 1'b0, b_poe = 1'b0, pe = 1'b0;
    logic pq = 1'b0, aq = 1'b0, fr_q = 1'b1, st_q = 1'b0, par_q = 1'b0, par_w;
    logic [3:0] req_cmd = '0, req_rd_be = '0, b_cbe = '0, cbe_q = '0, c1, c2, cbe_w;
    logic [31:0] b_ad = '0, ad_q = '0, dq, twd, ad_w;
    logic [63:0] req_addr = '0;
    logic [WQ_W-1:0] wq_data = '0;
    logic [CTL_N-1:0] b_ctl = '1, b_coe = '0, mask = '0, ctl_w;
    logic [31:0] ad_o, rd_data, tw_data, m_ad;
    logic ad_oe, cbe_oe, par_o, par_oe, req_ready, wq_ready, res_valid, tw_valid;
    logic par_err, m_aoe, m_par, m_poe, rd_valid;
    logic [3:0] cbe_o, tw_be, tbe;
    int nrd = 0;
    logic [2:0] res_code;
    logic [CTL_N-1:0] ctl_o, ctl_oe, m_ctl, m_coe;
    int n_fail = 0, num_checks = 0;

    always #12.5 clk = ~clk;
    // Undriven lines show the inverse of their last level; controls are pulled up
    assign ad_w  = ad_oe ? ad_o : m_aoe ? m_ad : b_aoe ? b_ad : ~ad_q;
    assign cbe_w = cbe_oe ? cbe_o : b_aoe ? b_cbe : ~cbe_q;
    assign par_w = par_oe ? par_o : m_poe ? m_par : b_poe ? b_par : ~par_q;
    assign ctl_w = (ctl_o | ~ctl_oe) & (m_ctl | ~m_coe) & (b_ctl | ~b_coe);

    always @(posedge clk) begin
        ad_q <= ad_w;
        cbe_q <= cbe_w;
        par_q <= par_w;
        pq <= ^{ad_w, cbe_w};
        aq <= b_aoe;
        fr_q <= ctl_w[CTL_FRAME];
        st_q <= fr_q & ~ctl_w[CTL_FRAME];
        if (fr_q & ~ctl_w[CTL_FRAME]) c1 <= cbe_w;
        if (st_q) c2 <= cbe_w;
        if (~ctl_w[CTL_IRDY] & ~ctl_w[CTL_TRDY]) dq <= ad_w;
        if (tw_valid) twd <= tw_data;
        if (tw_valid) tbe <= tw_be;
        if (rd_valid) nrd <= nrd + 1;
        pe <= pe | par_err;
    end
    always @(negedge clk) begin
        b_par <= pq;
        b_poe <= aq;
    end

    psp_port DUT (
        .clk(clk), .rstn(rstn), .own_gnt(own_gnt), .ad_i(ad_w), .ad_o(ad_o),
        .ad_oe(ad_oe), .cbe_i(cbe_w), .cbe_o(cbe_o), .cbe_oe(cbe_oe), .par_i(par_w),
        .par_o(par_o), .par_oe(par_oe), .ctl_i(ctl_w), .ctl_o(ctl_o), .ctl_oe(ctl_oe),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_dac(req_dac),
        .req_addr(req_addr), .req_rd_be(req_rd_be), .req_ready(req_ready),
        .wq_valid(wq_valid), .wq_data(wq_data), .wq_ready(wq_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .res_valid(res_valid), .res_code(res_code),
        .win_base(WB), .win_limit(WB + 32'hFFF), .tgt_busy(1'b0), .tgt_abort(1'b0),
        .tgt_rd_data(RD), .tw_valid(tw_valid), .tw_data(tw_data), .tw_be(tw_be),
        .par_err(par_err)
    );
    psp_tgt_model u_tgt (
        .clk(clk), .ctl_w(ctl_w), .ad_w(ad_w), .cbe_w(cbe_w), .mask(mask),
        .rdata(RD), .m_ctl(m_ctl), .m_coe(m_coe), .m_ad(m_ad), .m_aoe(m_aoe),
        .m_par(m_par), .m_poe(m_poe)
    );

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic t_park;
        own_gnt = 1'b1;
        repeat (4) @(negedge clk);
        chk({ad_oe, cbe_oe, par_oe, ad_o, cbe_o}, {3'b111, AD_PARK, CBE_PARK});
        own_gnt = 1'b0;
        repeat (3) @(negedge clk);
        chk({ad_oe, cbe_oe, par_oe}, 3'b000);
    endtask
    // Push until the queue refuses; valid and data held while refused
    task automatic t_fill;
        int k;
        k = 0;
        wq_valid = 1'b1;
        for (int n = 0; n < 8; n++) begin
            wq_data = {1'b1, 4'h0, WD + 32'(k)};
            if (wq_ready === 1'b1) k++;
            @(negedge clk);
        end
        wq_valid = 1'b0;
        chk(k, WQ_DEPTH);
        chk(wq_ready, 1'b0);
    endtask
    task automatic t_xfer(input logic [3:0] c, input logic d, input logic [4:0] m,
                          input logic [2:0] e);
        int n;
        mask = m;
        own_gnt = 1'b1;
        req_cmd = c;
        req_dac = d;
        req_rd_be = ~c;
        req_addr = {WB, WB};
        req_valid = 1'b1;
        for (n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        for (n = 0; n < 40 && res_valid !== 1'b1; n++) @(negedge clk);
        chk({n < 40, res_code}, {1'b1, e});
        repeat (3) @(negedge clk);
    endtask
    // Bench acts as a one-word write initiator towards the port
    task automatic t_tgt(input logic [31:0] a, input logic exp);
        int n;
        mask = '0;
        own_gnt = 1'b0;
        repeat (3) @(negedge clk);
        b_ad = a;
        b_cbe = CMD_MEM_WR;
        b_aoe = 1'b1;
        b_coe = 5'h03;
        b_ctl = 5'h1E;
        @(negedge clk);
        b_ad = WD;
        b_cbe = 4'h0;
        b_ctl = 5'h1D;
        for (n = 0; n < 8 && ctl_w[CTL_TRDY] !== 1'b0; n++) @(negedge clk);
        @(negedge clk);
        b_ctl = 5'h1F;
        b_aoe = 1'b0;
        @(negedge clk);
        b_coe = 5'h00;
        repeat (3) @(negedge clk);
        chk(n < 8, exp);
        if (exp) chk({twd, tbe}, {WD, 4'h0});
    endtask

    initial begin
        #100us;
        n_fail++;
        end_of_test;
    end
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        t_park;
        t_fill;
        t_xfer(CMD_MEM_WR, 1'b0, 5'h0C, RES_OK);
        chk({dq, c1}, {WD, CMD_MEM_WR});
        t_xfer(CMD_MEM_RD, 1'b1, 5'h0C, RES_OK);
        chk({rd_data, c1, c2}, {RD, CMD_DAC, CMD_MEM_RD});
        t_xfer(CMD_MEM_WR, 1'b0, 5'h1C, RES_DISC_DAT);
        chk(dq, WD + 32'h1);
        t_xfer(CMD_MEM_RD, 1'b0, 5'h18, RES_RETRY);
        t_xfer(CMD_MEM_RD, 1'b0, 5'h10, RES_TABORT);
        t_xfer(CMD_MEM_WR, 1'b0, 5'h00, RES_MABORT);
        t_xfer(CMD_MEM_WR, 1'b0, 5'h0C, RES_OK);
        chk({dq, wq_ready}, {WD + 32'h3, 1'b1});
        t_tgt(WB + 32'h10, 1'b1);
        t_tgt(WB - 32'h4, 1'b0);
        chk({pe, nrd}, {1'b0, 32'h1});
        end_of_test;
    end
endmodule // pci_bridge_secondary_port_bench
`default_nettype wire
